// file: rtl/apc_pkg.sv
// Constants and types of the converter serial port
package apc_pkg;
   localparam logic [3:0] ADDR_REV     = 4'h0;
   localparam logic [3:0] ADDR_STATUS  = 4'h2;
   localparam logic [3:0] ADDR_CTRL    = 4'h3;
   localparam logic [3:0] ADDR_CFG2    = 4'h5;
   localparam logic [3:0] ADDR_CFG4    = 4'h7;
   localparam logic [3:0] ADDR_MAPLAST = 4'he;
   localparam logic [3:0] ADDR_MAPCRC  = 4'hf;
   localparam int         BIT_RDY      = 7;
   localparam int         BIT_SPI_ERR  = 6;
   localparam int         BIT_REG_ERR  = 5;
   localparam int         BIT_SDO_SEL  = 0;
   localparam logic [7:0] RST_REG      = 8'h00;
   localparam logic [7:0] CRC_PRESET   = 8'hff;
   localparam logic [7:0] CRC_POLY     = 8'h07;
   localparam logic [1:0] OP_READ      = 2'h1;
   localparam logic [1:0] OP_WRITE     = 2'h2;
   localparam logic [5:0] FRAME_LAST   = 6'h27;
   localparam logic [5:0] FRAME_RST    = 6'h18;
   localparam logic [5:0] CNT_RST      = 6'h00;

   typedef struct packed {
      logic w16;
      logic stat_en;
      logic link_crc;
      logic map_crc;
   } apc_cfg_s;

   typedef struct packed {
      logic [1:0] op;
      logic [1:0] rsv;
      logic [3:0] addr;
      logic [7:0] data;
   } apc_cmd_s;

   function automatic logic [7:0] apc_crc_byte(input logic [7:0] c,
                                               input logic [7:0] b);
      logic [7:0] r;
      r = c;
      for (int i = 7; i >= 0; i--)
      begin
         r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? CRC_POLY : 8'h00);
      end
      return r;
   endfunction
endpackage

// file: rtl/apc_serial_port.sv
// Serial port with link CRC, register map and map CRC watch
`timescale 1ns/100ps
`default_nettype none
module apc_serial_port
#(
   parameter int         MAP_DEPTH = 16,
   // Arbitrary revision value
   parameter logic [7:0] REV_VALUE = 8'h5a
)
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        sdi,
   input  wire logic [23:0] conv_data,
   input  wire logic        conv_valid,
   output logic             serial_out_ready_pin_o,
   output logic             serial_out_ready_pin_oe_n,
   output logic             conversion_ready_n,
   output logic [7:0]       ctrl_byte,
   output logic             out_pin_function_sel
);
   // Link side, clocked by sclk
   logic [39:0] rx_q;
   logic [39:0] tx_word_q;
   logic [5:0]  bit_cnt_q;
   logic        tx_bit_q;
   logic        tx_next;
   logic        rdy_q;

   assign tx_next = (bit_cnt_q <= apc_pkg::FRAME_LAST) ?
                    tx_word_q[apc_pkg::FRAME_LAST - bit_cnt_q] : 1'b0;

   // Read on the system side only once chip select has synced high
   always_ff @(negedge sclk)
   begin
      rx_q <= {rx_q[38:0], sdi};
   end

   // Chip select high holds the shifter in reset
   always_ff @(posedge sclk or posedge cs_n)
   begin
      if (cs_n)
      begin
         bit_cnt_q <= apc_pkg::CNT_RST;
         tx_bit_q  <= 1'b0;
      end
      else
      begin
         tx_bit_q  <= tx_next;
         if (bit_cnt_q <= apc_pkg::FRAME_LAST)
         begin
            bit_cnt_q <= bit_cnt_q + 6'h01;
         end
      end
   end

   // Before the first edge the pin may show data-ready
   assign serial_out_ready_pin_o = (bit_cnt_q == apc_pkg::CNT_RST &&
                                    out_pin_function_sel) ?
                                   ~rdy_q : tx_bit_q;
   assign serial_out_ready_pin_oe_n = cs_n;

   // System side
   logic        cs_m_q;
   logic        cs_s_q;
   logic        cs_d_q;
   logic        frame_end;
   logic        frame_start;

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         cs_m_q <= 1'b1;
         cs_s_q <= 1'b1;
         cs_d_q <= 1'b1;
      end
      else
      begin
         cs_m_q <= cs_n;
         cs_s_q <= cs_m_q;
         cs_d_q <= cs_s_q;
      end
   end

   assign frame_end   = cs_s_q & ~cs_d_q;
   assign frame_start = ~cs_s_q & cs_d_q;

   logic [7:0]        mem_q [16];
   logic [7:0]        rd_arr [16];
   logic [7:0]        status_byte;
   logic              spi_err_q;
   logic              reg_err_q;
   logic              rd_pend_q;
   logic [7:0]        rd_byte_q;
   logic [23:0]       conv_q;
   apc_pkg::apc_cfg_s cfg;
   apc_pkg::apc_cmd_s cmd;
   logic [7:0]        cmd_crc;
   logic              crc_ok;
   logic              is_rd;
   logic              is_wr;
   logic              wr_ok;
   logic              wr_mem;
   logic              st_clr_spi;
   logic              st_clr_reg;
   logic [7:0]        map_crc;
   logic              map_bad;

   assign cfg = apc_pkg::apc_cfg_s'(mem_q[apc_pkg::ADDR_CFG4][3:0]);
   assign out_pin_function_sel =
      mem_q[apc_pkg::ADDR_CFG2][apc_pkg::BIT_SDO_SEL];
   assign ctrl_byte = mem_q[apc_pkg::ADDR_CTRL];
   assign conversion_ready_n = ~rdy_q;

   // Only the trailing command bytes count, padding is dropped
   assign cmd = cfg.link_crc ? rx_q[23:8] : rx_q[15:0];
   assign cmd_crc = apc_pkg::apc_crc_byte(
      apc_pkg::apc_crc_byte(apc_pkg::CRC_PRESET, cmd[15:8]),
      cmd[7:0]);
   assign crc_ok = ~cfg.link_crc | (cmd_crc == rx_q[7:0]);
   assign is_rd = crc_ok & (cmd.op == apc_pkg::OP_READ) &
                  (cmd.rsv == 2'h0);
   assign is_wr = crc_ok & (cmd.op == apc_pkg::OP_WRITE) &
                  (cmd.rsv == 2'h0);
   assign wr_ok = frame_end & is_wr &
                  (~spi_err_q | cmd.addr == apc_pkg::ADDR_STATUS);
   assign wr_mem = wr_ok & (int'(cmd.addr) < MAP_DEPTH) &
                   (cmd.addr != apc_pkg::ADDR_REV) &
                   (cmd.addr != apc_pkg::ADDR_STATUS);
   assign st_clr_spi = wr_ok & (cmd.addr == apc_pkg::ADDR_STATUS) &
                       cmd.data[apc_pkg::BIT_SPI_ERR];
   assign st_clr_reg = wr_ok & (cmd.addr == apc_pkg::ADDR_STATUS) &
                       cmd.data[apc_pkg::BIT_REG_ERR];

   always_comb
   begin
      status_byte = 8'h00;
      status_byte[apc_pkg::BIT_RDY]     = rdy_q;
      status_byte[apc_pkg::BIT_SPI_ERR] = spi_err_q;
      status_byte[apc_pkg::BIT_REG_ERR] = reg_err_q;
   end

   // Read view of the map; off-map addresses read zero
   always_comb
   begin
      for (int i = 0; i < 16; i++)
      begin
         if (i >= MAP_DEPTH)
            rd_arr[i] = 8'h00;
         else if (4'(i) == apc_pkg::ADDR_REV)
            rd_arr[i] = REV_VALUE;
         else if (4'(i) == apc_pkg::ADDR_STATUS)
            rd_arr[i] = status_byte;
         else
            rd_arr[i] = mem_q[i];
      end
   end

   // Map CRC over the read view of addresses 0x0 to 0xe except status and control, same algorithm as the link
   always_comb
   begin
      map_crc = apc_pkg::CRC_PRESET;
      for (int i = 0; i < 16; i++)
      begin
         if (4'(i) <= apc_pkg::ADDR_MAPLAST &&
             4'(i) != apc_pkg::ADDR_STATUS &&
             4'(i) != apc_pkg::ADDR_CTRL)
            map_crc = apc_pkg::apc_crc_byte(map_crc, rd_arr[i]);
      end
   end

   assign map_bad = cfg.map_crc &
                    (map_crc != mem_q[apc_pkg::ADDR_MAPCRC]);

   always_ff @(posedge sys_clk)
   begin
      for (int i = 0; i < 16; i++)
      begin
         if (srst)
            mem_q[i] <= apc_pkg::RST_REG;
         else if (wr_mem && cmd.addr == 4'(i))
            mem_q[i] <= cmd.data;
      end
   end

   // Flags: a new event wins over a clear in the same cycle
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         spi_err_q <= 1'b0;
         reg_err_q <= 1'b0;
         rdy_q     <= 1'b0;
      end
      else
      begin
         spi_err_q <= (frame_end & ~crc_ok) |
                      (spi_err_q & ~st_clr_spi);
         reg_err_q <= map_bad | (reg_err_q & ~st_clr_reg);
         rdy_q     <= conv_valid | (rdy_q & ~frame_start);
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         rd_pend_q <= 1'b0;
         rd_byte_q <= 8'h00;
         conv_q    <= 24'h000000;
      end
      else
      begin
         if (frame_end)
         begin
            rd_pend_q <= is_rd;
            rd_byte_q <= rd_arr[cmd.addr];
         end
         if (conv_valid)
            conv_q <= conv_data;
      end
   end

   // Output frame assembly
   logic [23:0] fld;
   logic [23:0] fld_al;
   logic [31:0] payload;
   logic [2:0]  nb;
   logic [7:0]  out_crc;
   logic [39:0] frame;
   logic [5:0]  frame_len;

   assign fld = rd_pend_q ? {rd_byte_q, 16'h0000} : conv_q;
   assign fld_al = cfg.w16 ? {fld[23:8], 8'h00} : fld;
   assign payload = cfg.stat_en ? {status_byte, fld_al} : {fld_al, 8'h00};
   assign nb = 3'h2 + {2'h0, ~cfg.w16} + {2'h0, cfg.stat_en};
   assign frame_len = {nb, 3'h0} + (cfg.link_crc ? 6'h08 : 6'h00);

   always_comb
   begin
      out_crc = apc_pkg::CRC_PRESET;
      for (int k = 0; k < 4; k++)
      begin
         if (3'(k) < nb)
            out_crc = apc_pkg::apc_crc_byte(out_crc,
                                            payload[31 - 8 * k -: 8]);
      end
   end

   always_comb
   begin
      frame = {payload, 8'h00};
      if (cfg.link_crc)
         frame[apc_pkg::FRAME_LAST - {nb, 3'h0} -: 8] = out_crc;
   end

   // Word is frozen while a frame runs so the shifter reads it safely
   always_ff @(posedge sys_clk)
   begin
      if (srst)
         tx_word_q <= 40'h0000000000;
      else if (cs_s_q)
         tx_word_q <= frame;
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (srst);

   property p_crc_fail;
      frame_end && cfg.link_crc && cmd_crc != rx_q[7:0] |=> spi_err_q;
   endproperty
   a_crc_fail: assert property (p_crc_fail)
      else $error("crc failure did not flag link error");

   logic [7:0] wr_tgt;
   assign wr_tgt = mem_q[cmd.addr];

   property p_wr_block;
      frame_end && is_wr && spi_err_q &&
      cmd.addr != apc_pkg::ADDR_STATUS |=> $stable(wr_tgt);
   endproperty
   a_wr_block: assert property (p_wr_block)
      else $error("write passed while link error set");

   // Command acceptance, flags, frame length, output word and data ready
   property p_crc_drop;
      frame_end && !crc_ok |=> $stable(wr_tgt);
   endproperty
   a_crc_drop: assert property (p_crc_drop)
      else $error("command with bad crc changed a register");

   property p_wr_land;
      wr_mem |=> mem_q[$past(cmd.addr)] == $past(cmd.data);
   endproperty
   a_wr_land: assert property (p_wr_land)
      else $error("accepted write did not land");

   property p_spi_clr;
      st_clr_spi |=> !spi_err_q;
   endproperty
   a_spi_clr: assert property (p_spi_clr)
      else $error("link error not cleared by writing one");

   property p_reg_clr;
      st_clr_reg && !map_bad |=> !reg_err_q;
   endproperty
   a_reg_clr: assert property (p_reg_clr)
      else $error("map error not cleared by writing one");

   property p_len_w16;
      cfg.w16 && cfg.stat_en && cfg.link_crc |-> frame_len == 6'h20;
   endproperty
   a_len_w16: assert property (p_len_w16)
      else $error("frame length wrong for short data with status and crc");

   property p_noop_idle;
      frame_end && cmd == 16'h0000 |=> !rd_pend_q && $stable(wr_tgt);
   endproperty
   a_noop_idle: assert property (p_noop_idle)
      else $error("no-operation command had an effect");

   property p_rd_drop;
      frame_end && !crc_ok |=> !rd_pend_q;
   endproperty
   a_rd_drop: assert property (p_rd_drop)
      else $error("read served after failed command crc");

   property p_rd_keep;
      frame_end && is_rd && spi_err_q |=> rd_pend_q;
   endproperty
   a_rd_keep: assert property (p_rd_keep)
      else $error("read refused while link error set");

   property p_len_rst;
      $past(srst) |-> frame_len == apc_pkg::FRAME_RST;
   endproperty
   a_len_rst: assert property (p_len_rst)
      else $error("frame length after reset not 24");

   property p_noop;
      frame_end && cfg.link_crc && rx_q[23:0] == 24'h0000d7 |-> crc_ok;
   endproperty
   a_noop: assert property (p_noop)
      else $error("noop crc not accepted");

   property p_map_err;
      map_bad ##1 !st_clr_reg |-> reg_err_q ##1 reg_err_q;
   endproperty
   a_map_err: assert property (p_map_err)
      else $error("map mismatch did not hold map error");

   property p_map_off;
      !cfg.map_crc && !reg_err_q |=> !reg_err_q;
   endproperty
   a_map_off: assert property (p_map_off)
      else $error("map error set while check disabled");

   property p_freeze;
      !cs_s_q && !cs_d_q |=> $stable(tx_word_q);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("output word changed during frame");

   property p_rdy;
      conv_valid |=> !conversion_ready_n;
   endproperty
   a_rdy: assert property (p_rdy)
      else $error("data ready not shown");

   c_read: cover property (frame_end && is_rd ##[2:200] frame_end);
   c_write: cover property (wr_mem);
   c_spi_err: cover property ($rose(spi_err_q));
   c_reg_err: cover property ($rose(reg_err_q));
   c_map_clr: cover property (st_clr_reg);
endmodule
`default_nettype wire

// file: bench/apc_host.sv
// Host controller model: SPI mode 1 master that shifts whole frames
`timescale 1ns/100ps
`default_nettype none
module apc_host
(
   output logic      sclk,
   output logic      cs_n,
   output logic      sdi,
   input  wire logic sdo
);
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi  = 1'b0;
   end

   // Clock stands low outside frames; 64 ns period inside
   task automatic frame(input int n, input logic [39:0] din,
                        output logic [39:0] dout, output logic pre);
      dout = 40'h0;
      // Offset keeps the link clock out of phase with the system clock
      #7;
      cs_n = 1'b0;
      #200;
      pre = sdo;
      for (int i = n - 1; i >= 0; i--)
      begin
         sclk = 1'b1;
         sdi  = din[i];
         #32;
         sclk = 1'b0;
         dout = {dout[38:0], sdo};
         #32;
      end
      cs_n = 1'b1;
      sdi  = ~sdi;
      #400;
   endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Self-checking bench of the converter serial port
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic        sys_clk = 1'b0;
   logic        srst = 1'b1;
   logic [23:0] conv_data = 24'habcdef;
   logic        conv_valid = 1'b0;
   wire         sclk, cs_n, sdi, sdo_w;
   logic        pin_o, oe_n, rdy_n, sel;
   logic [7:0]  ctrl;
   logic [39:0] d;
   logic        pre;
   logic        w16 = 1'b0, st = 1'b0, cc = 1'b0;
   int          fail_count = 0, n_tests = 0;

   always #20 sys_clk = ~sys_clk;
   assign sdo_w = oe_n ? 1'bz : pin_o;

   apc_serial_port #(.MAP_DEPTH(16), .REV_VALUE(8'h3c)) DUT
   (
      .sys_clk(sys_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi), .conv_data(conv_data), .conv_valid(conv_valid),
      .serial_out_ready_pin_o(pin_o),
      .serial_out_ready_pin_oe_n(oe_n),
      .conversion_ready_n(rdy_n), .ctrl_byte(ctrl),
      .out_pin_function_sel(sel)
   );
   apc_host HOST (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_w));

   // Bit-serial division, leading byte already inverted by caller
   function automatic logic [7:0] crc_add(input logic [7:0] r,
                                          input logic [7:0] b);
      for (int i = 7; i >= 0; i--)
         r = {r[6:0], 1'b0} ^ ((r[7] ^ b[i]) ? 8'h07 : 8'h00);
      return r;
   endfunction

   function automatic int olen();
      return (w16 ? 16 : 24) + (st ? 8 : 0) + (cc ? 8 : 0);
   endfunction

   function automatic logic [39:0] ef(input logic [7:0] s,
                                      input logic [23:0] v);
      logic [39:0] f;
      logic [7:0]  r;
      int          nb;
      f = st ? {32'h0, s} : 40'h0;
      nb = st ? 1 : 0;
      f = w16 ? (f << 16) | 40'(v[23:8]) : (f << 24) | 40'(v);
      nb = nb + (w16 ? 2 : 3);
      r = 8'h00;
      for (int i = nb - 1; i >= 0; i--)
         r = crc_add(r, f[i*8 +: 8] ^ ((i == nb - 1) ? 8'hff : 8'h00));
      return cc ? {f[31:0], r} : f;
   endfunction

   function automatic logic [7:0] mapcrc();
      logic [7:0] r;
      logic [7:0] v;
      r = 8'h00;
      for (int a = 0; a < 15; a++)
         if (a != 2 && a != 3)
         begin
            v = (a == 0) ? 8'h3c : (a == 5) ? 8'h01 :
                (a == 7) ? 8'h0f : 8'h00;
            r = crc_add(r, v ^ ((a == 0) ? 8'hff : 8'h00));
         end
      return r;
   endfunction

   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         fail_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Command padded with leading zeros to the output length
   task automatic cmd(input logic [7:0] a, input logic [7:0] b,
                      input logic bad = 1'b0);
      logic [39:0] din;
      logic [7:0]  r;
      r = crc_add(crc_add(8'h00, a ^ 8'hff), b) ^ {7'h0, bad};
      din = cc ? {16'h0, a, b, r} : {24'h0, a, b};
      HOST.frame(olen(), din, d, pre);
   endtask

   task automatic conv();
      @(posedge sys_clk);
      conv_valid <= 1'b1;
      @(posedge sys_clk);
      conv_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic final_report();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial
   begin
      #2ms;
      fail_count++;
      final_report();
   end

   initial
   begin
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(40'(ctrl), 40'h0);
      chk(40'(oe_n), 40'h1);
      conv();
      chk(40'(rdy_n), 40'h0);
      cmd(8'h83, 8'h5c);
      chk(d, ef(8'h0, 24'habcdef));
      chk(40'(pre), 40'h0);
      chk(40'(ctrl), 40'h5c);
      chk(40'(rdy_n), 40'h1);
      HOST.frame(32, 40'h12_34_83_a5, d, pre);
      chk(40'(ctrl), 40'ha5);
      $display("test basic done");
      cmd(8'h85, 8'h01);
      chk(40'(sel), 40'h1);
      cmd(8'h45, 8'h00);
      cmd(8'h43, 8'h00);
      chk(d, ef(8'h0, 24'h010000));
      chk(40'(pre), 40'h1);
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h0, 24'ha50000));
      $display("test read done");
      cmd(8'h87, 8'h0e);
      w16 = 1'b1;
      st = 1'b1;
      cc = 1'b1;
      conv();
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h80, 24'habcdef));
      cmd(8'h83, 8'h11, 1'b1);
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h40, 24'habcdef));
      chk(40'(ctrl), 40'ha5);
      cmd(8'h83, 8'h22);
      chk(40'(ctrl), 40'ha5);
      cmd(8'h45, 8'h00);
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h40, 24'h010000));
      cmd(8'h82, 8'h40);
      cmd(8'h83, 8'h22);
      chk(40'(ctrl), 40'h22);
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h00, 24'habcdef));
      $display("test link check done");
      cmd(8'h8f, mapcrc());
      cmd(8'h87, 8'h0f);
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h00, 24'habcdef));
      cmd(8'h8f, ~mapcrc());
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h20, 24'habcdef));
      cmd(8'h8f, mapcrc());
      cmd(8'h82, 8'h20);
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h00, 24'habcdef));
      $display("test map check done");
      @(posedge sys_clk);
      srst <= 1'b1;
      repeat (4) @(posedge sys_clk);
      srst <= 1'b0;
      w16 = 1'b0;
      st = 1'b0;
      cc = 1'b0;
      repeat (4) @(posedge sys_clk);
      chk(40'(rdy_n), 40'h1);
      chk(40'(ctrl), 40'h0);
      conv();
      cmd(8'h00, 8'h00);
      chk(d, ef(8'h0, 24'habcdef));
      $display("test reset done");
      final_report();
   end
endmodule
`default_nettype wire
